// File: rtl/offset_expand_pkg.sv
// package: constants and types for the channel offset/expand scaler
package offset_expand_pkg;
  localparam int DATA_W = 24;
  localparam int PCT_W = 16;
  localparam int PCT_FRAC = 8;
  localparam int FS_CODE = 24'h100000;
  localparam int CLAMP_NUM = 11;
  localparam int CLAMP_DEN = 10;
  localparam logic [1:0] EXP_OFF = 2'h0;
  localparam logic [1:0] EXP_X10 = 2'h1;
  localparam logic [1:0] EXP_X100 = 2'h2;
  localparam int FACTOR_X10 = 10;
  localparam int FACTOR_X100 = 100;
  localparam int OUT_VOLTS = 10;
  localparam int SIN_W = 16;
  localparam int SIN_FRAC = 14;

  typedef enum logic [1:0] {QTY_X, QTY_Y, QTY_R} qty_t;

  typedef struct packed {
    logic expand_key;
    logic offset_toggle_key;
    logic auto_offset_key;
    logic output_key;
    logic offset_write;
    logic signed [PCT_W-1:0] offset_value;
    logic phase_step;
    logic signed [SIN_W-1:0] phase_cos;
    logic signed [SIN_W-1:0] phase_sin;
  } ctrl_t;

  typedef struct packed {
    logic overload_flag;
    logic xy_offset_flag;
    logic magnitude_offset_flag;
    logic expand_flag;
    logic output_is_display;
  } flags_t;
endpackage

// File: rtl/scale_lane.sv
// one quantity lane: offset, expand, 110 percent clamp
module scale_lane
  import offset_expand_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // quantity in, as fraction of sensitivity (FS_CODE = full scale)
  input wire logic signed [DATA_W-1:0] value_i,
  input wire logic signed [PCT_W-1:0] offset_pct_i,
  input wire logic offset_en_i,
  input wire logic [1:0] expand_i,
  // scaled result, full scale output = FS_CODE
  output logic signed [DATA_W-1:0] out_o,
  output logic over_o
);
  logic signed [47:0] off_code;
  logic signed [47:0] diff;
  logic signed [47:0] scaled;
  logic signed [47:0] lim;
  always_comb begin
    off_code = offset_en_i ? ((48'(offset_pct_i) * 48'(FS_CODE)) / 48'(100 << PCT_FRAC)) : 48'sh0;
    diff = 48'(value_i) - off_code;
    unique case (expand_i)
      EXP_X10: scaled = diff * 48'(FACTOR_X10);
      EXP_X100: scaled = diff * 48'(FACTOR_X100);
      default: scaled = diff;
    endcase
    lim = 48'((FS_CODE * CLAMP_NUM) / CLAMP_DEN);
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_o <= '0;
      over_o <= 1'b0;
    end else if (scaled > lim) begin
      out_o <= lim[DATA_W-1:0];
      over_o <= 1'b1;
    end else if (scaled < -lim) begin
      out_o <= DATA_W'(-lim);
      over_o <= 1'b1;
    end else begin
      out_o <= scaled[DATA_W-1:0];
      over_o <= 1'b0;
    end
  end
  AST_CLAMP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (out_o <= 24'(lim)) && (out_o >= -24'(lim))) else $error("lane output beyond clamp");
endmodule

// File: rtl/channel_offset_expand_scaler.sv
// channel offset/expand scaler top: settings, key handling, output select
// Notes on behaviour
// - offsets are held and reported as percent of full-scale sensitivity.
// - offset percent survives sensitivity change; X/Y offsets follow phase changes.
// - expand factors ten and hundred scale output gain.
// - expand key cycles off, x10, x100, off for displayed quantity.
// - output clamped at 110 percent of display full scale; overload flags.
// - output key toggles analog source between display quantity and X.
// - in display mode a new display selection drives the output.
// - R is computed from offset-corrected X and Y.
// - X offset and expand stay active on X output while R displayed.
// - separate settings for X, Y, R; keys act on displayed quantity.
// - offset toggle while R displayed switches R offset and its flag.
// - R offset and expand never touch X or Y.
// - disabling X offset disables Y offset; XY flag clears.
// - expand flag high when displayed quantity has nonzero expand.
// - XY flag high while XY offsets on and affect display, R included.
// - output = (quantity/sens - offset) * expand * 10 V.
// - X and Y offsets enabled and disabled only as a pair.
// - on phase change the XY offset vector rotates by minus the change.
// - auto offset zeroes the offset-corrected displayed quantity.
module channel_offset_expand_scaler
  import offset_expand_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // demodulator samples, fraction of sensitivity
  input wire logic signed [offset_expand_pkg::DATA_W-1:0] x_i,
  input wire logic signed [offset_expand_pkg::DATA_W-1:0] y_i,
  // panel and remote settings
  input wire offset_expand_pkg::qty_t display_sel_i,
  input wire offset_expand_pkg::ctrl_t ctrl_i,
  // results
  output logic signed [offset_expand_pkg::DATA_W-1:0] analog_out_o,
  output logic signed [offset_expand_pkg::DATA_W-1:0] display_o,
  output logic signed [offset_expand_pkg::PCT_W-1:0] offset_pct_o,
  output offset_expand_pkg::flags_t flags_o
);
  import offset_expand_pkg::*;

  logic signed [PCT_W-1:0] x_off_reg, y_off_reg, r_off_reg;
  logic xy_en_reg, r_en_reg, out_disp_reg;
  logic [1:0] x_exp_reg, y_exp_reg, r_exp_reg;
  logic signed [DATA_W-1:0] xc, yc, r_mag;
  logic signed [DATA_W-1:0] x_lane, y_lane, r_lane;
  logic x_ov, y_ov, r_ov;
  logic signed [47:0] rx_next, ry_next;

  function automatic logic [1:0] exp_step(input logic [1:0] e);
    exp_step = (e == EXP_X100) ? EXP_OFF : e + 2'h1;
  endfunction

  function automatic logic signed [PCT_W-1:0] to_pct(input logic signed [DATA_W-1:0] v);
    to_pct = PCT_W'((48'(v) * 48'(100 << PCT_FRAC)) / 48'(FS_CODE));
  endfunction

  function automatic logic signed [DATA_W-1:0] abs_v(input logic signed [DATA_W-1:0] v);
    abs_v = v[DATA_W-1] ? -v : v;
  endfunction

  // offset corrected X/Y feed R
  always_comb begin
    xc = xy_en_reg ? x_i - DATA_W'((48'(x_off_reg) * 48'(FS_CODE)) / 48'(100 << PCT_FRAC)) : x_i;
    yc = xy_en_reg ? y_i - DATA_W'((48'(y_off_reg) * 48'(FS_CODE)) / 48'(100 << PCT_FRAC)) : y_i;
    // alpha-max beta-min magnitude estimate
    if (abs_v(xc) > abs_v(yc)) begin
      r_mag = abs_v(xc) + (abs_v(yc) >>> 1) - (abs_v(yc) >>> 3);
    end else begin
      r_mag = abs_v(yc) + (abs_v(xc) >>> 1) - (abs_v(xc) >>> 3);
    end
    rx_next = (48'(x_off_reg) * 48'(ctrl_i.phase_cos) + 48'(y_off_reg) * 48'(ctrl_i.phase_sin)) >>> SIN_FRAC;
    ry_next = (48'(y_off_reg) * 48'(ctrl_i.phase_cos) - 48'(x_off_reg) * 48'(ctrl_i.phase_sin)) >>> SIN_FRAC;
  end

  // X and Y lanes see raw inputs with their own settings only
  scale_lane u_x (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .value_i(x_i), .offset_pct_i(x_off_reg),
    .offset_en_i(xy_en_reg), .expand_i(x_exp_reg), .out_o(x_lane), .over_o(x_ov)
  );
  scale_lane u_y (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .value_i(y_i), .offset_pct_i(y_off_reg),
    .offset_en_i(xy_en_reg), .expand_i(y_exp_reg), .out_o(y_lane), .over_o(y_ov)
  );
  scale_lane u_r (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .value_i(r_mag), .offset_pct_i(r_off_reg),
    .offset_en_i(r_en_reg), .expand_i(r_exp_reg), .out_o(r_lane), .over_o(r_ov)
  );

  // offset settings
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      x_off_reg <= '0;
      y_off_reg <= '0;
      r_off_reg <= '0;
      xy_en_reg <= 1'b0;
      r_en_reg <= 1'b0;
    end else begin
      if (ctrl_i.phase_step) begin
        x_off_reg <= rx_next[PCT_W-1:0];
        y_off_reg <= ry_next[PCT_W-1:0];
      end
      if (ctrl_i.offset_toggle_key) begin
        if (display_sel_i == QTY_R) begin
          r_en_reg <= !r_en_reg;
        end else begin
          xy_en_reg <= !xy_en_reg;
        end
      end else if (ctrl_i.auto_offset_key) begin
        if (display_sel_i == QTY_R) begin
          r_off_reg <= to_pct(r_mag);
          r_en_reg <= 1'b1;
        end else begin
          x_off_reg <= to_pct(x_i);
          y_off_reg <= to_pct(y_i);
          xy_en_reg <= 1'b1;
        end
      end else if (ctrl_i.offset_write) begin
        unique case (display_sel_i)
          QTY_X: x_off_reg <= ctrl_i.offset_value;
          QTY_Y: y_off_reg <= ctrl_i.offset_value;
          default: r_off_reg <= ctrl_i.offset_value;
        endcase
      end
    end
  end

  // expand settings
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      x_exp_reg <= EXP_OFF;
      y_exp_reg <= EXP_OFF;
      r_exp_reg <= EXP_OFF;
    end else if (ctrl_i.expand_key) begin
      unique case (display_sel_i)
        QTY_X: x_exp_reg <= exp_step(x_exp_reg);
        QTY_Y: y_exp_reg <= exp_step(y_exp_reg);
        default: r_exp_reg <= exp_step(r_exp_reg);
      endcase
    end
  end

  // output source select
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_disp_reg <= 1'b0;
    end else if (ctrl_i.output_key) begin
      out_disp_reg <= !out_disp_reg;
    end
  end

  // registered outputs and indicators
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_out_o <= '0;
      display_o <= '0;
      offset_pct_o <= '0;
      flags_o <= '0;
    end else begin
      unique case (display_sel_i)
        QTY_X: begin
          display_o <= x_lane;
          offset_pct_o <= x_off_reg;
          flags_o.expand_flag <= x_exp_reg != EXP_OFF;
          flags_o.magnitude_offset_flag <= 1'b0;
        end
        QTY_Y: begin
          display_o <= y_lane;
          offset_pct_o <= y_off_reg;
          flags_o.expand_flag <= y_exp_reg != EXP_OFF;
          flags_o.magnitude_offset_flag <= 1'b0;
        end
        default: begin
          display_o <= r_lane;
          offset_pct_o <= r_off_reg;
          flags_o.expand_flag <= r_exp_reg != EXP_OFF;
          flags_o.magnitude_offset_flag <= r_en_reg;
        end
      endcase
      flags_o.xy_offset_flag <= xy_en_reg;
      flags_o.output_is_display <= out_disp_reg;
      if (out_disp_reg) begin
        unique case (display_sel_i)
          QTY_X: begin
            analog_out_o <= x_lane;
            flags_o.overload_flag <= x_ov;
          end
          QTY_Y: begin
            analog_out_o <= y_lane;
            flags_o.overload_flag <= y_ov;
          end
          default: begin
            analog_out_o <= r_lane;
            flags_o.overload_flag <= r_ov;
          end
        endcase
      end else begin
        analog_out_o <= x_lane;
        flags_o.overload_flag <= x_ov;
      end
    end
  end

  AST_EXPAND_CYCLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ctrl_i.expand_key && display_sel_i == QTY_X && x_exp_reg == EXP_X100 |=> x_exp_reg == EXP_OFF)
    else $error("expand did not wrap to off");
  AST_OUT_TOGGLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ctrl_i.output_key |=> out_disp_reg != $past(out_disp_reg)) else $error("output select did not toggle");
  AST_X_SOURCE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !out_disp_reg |=> analog_out_o == $past(x_lane)) else $error("X source not on output");
  AST_XY_PAIR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ctrl_i.offset_toggle_key && display_sel_i == QTY_Y && xy_en_reg |=> !xy_en_reg ##1 !flags_o.xy_offset_flag)
    else $error("xy offset pair not cleared");
  AST_R_TOGGLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ctrl_i.offset_toggle_key && display_sel_i == QTY_R |=> r_en_reg != $past(r_en_reg) && $stable(xy_en_reg))
    else $error("R offset toggle wrong");
  AST_EXP_FLAG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    display_sel_i == QTY_R && r_exp_reg != EXP_OFF |=> flags_o.expand_flag) else $error("expand flag missing");
  AST_AUTO_XY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ctrl_i.auto_offset_key && !ctrl_i.offset_toggle_key && display_sel_i == QTY_X |=> xy_en_reg)
    else $error("auto offset did not enable xy");
  AST_OVL_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !out_disp_reg |=> flags_o.overload_flag == $past(x_ov)) else $error("overload flag mismatch");
endmodule

// File: sim/panel_model.sv
// partner model: front-panel key pulser and output converter
module panel_model
  import offset_expand_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // converter input
  input wire logic signed [DATA_W-1:0] analog_out_i,
  // panel keys and converter result
  output ctrl_t ctrl_o,
  output logic signed [DATA_W-1:0] volts_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ctrl_o = '0;
  // converter takes one sample each clock
  always @(posedge ref_clk_i) volts_o <= analog_out_i;
  // one key pulse, a single cycle wide, changed off the sampling edge
  task automatic press(input int k, input logic signed [PCT_W-1:0] v, input logic signed [SIN_W-1:0] c, s);
    @(negedge ref_clk_i);
    ctrl_o.expand_key = (k == 0);
    ctrl_o.offset_toggle_key = (k == 1);
    ctrl_o.auto_offset_key = (k == 2);
    ctrl_o.output_key = (k == 3);
    ctrl_o.offset_write = (k == 4);
    ctrl_o.phase_step = (k == 5);
    ctrl_o.offset_value = v;
    ctrl_o.phase_cos = c;
    ctrl_o.phase_sin = s;
    @(negedge ref_clk_i);
    ctrl_o = '0;
  endtask
endmodule

// File: sim/channel_offset_expand_scaler_test.sv
// testbench for the channel offset/expand scaler
module channel_offset_expand_scaler_test;
  timeunit 1ns;
  timeprecision 1ps;
  import offset_expand_pkg::*;
  localparam int EXP = 0;
  localparam int TOG = 1;
  localparam int AUTO = 2;
  localparam int OUTK = 3;
  localparam int WR = 4;
  localparam int PH = 5;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic signed [DATA_W-1:0] x_i = '0;
  logic signed [DATA_W-1:0] y_i = '0;
  qty_t sel = QTY_X;
  ctrl_t ctrl;
  logic signed [DATA_W-1:0] aout, disp, volts;
  logic signed [PCT_W-1:0] pct;
  flags_t fl;
  int error_cnt = 0;
  int n_tests = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  channel_offset_expand_scaler dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .x_i(x_i), .y_i(y_i),
    .display_sel_i(sel), .ctrl_i(ctrl), .analog_out_o(aout), .display_o(disp), .offset_pct_o(pct),
    .flags_o(fl));
  panel_model m_u (.ref_clk_i(ref_clk_i), .analog_out_i(aout), .ctrl_o(ctrl), .volts_o(volts));
  task automatic chk_val(input string n, input logic [DATA_W-1:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic drive(input logic signed [DATA_W-1:0] x, y, input qty_t d);
    @(negedge ref_clk_i);
    x_i = x;
    y_i = y;
    sel = d;
    repeat (4) @(negedge ref_clk_i);
  endtask
  task automatic key(input int k, input logic signed [PCT_W-1:0] v, input logic signed [SIN_W-1:0] c, s);
    m_u.press(k, v, c, s);
    repeat (4) @(negedge ref_clk_i);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_expand;
    drive(24'h1000, 24'h0, QTY_X);
    key(EXP, 16'h0, 16'h0, 16'h0);
    chk_val("x10", 24'hA000, volts);
    chk_bit("expf", 1'b1, fl.expand_flag);
    key(EXP, 16'h0, 16'h0, 16'h0);
    chk_val("x100", 24'h64000, volts);
    key(EXP, 16'h0, 16'h0, 16'h0);
    chk_val("exp off", 24'h1000, volts);
    chk_bit("expf", 1'b0, fl.expand_flag);
  endtask
  task automatic t_clamp;
    drive(24'h10000, 24'h0, QTY_X);
    key(EXP, 16'h0, 16'h0, 16'h0);
    key(EXP, 16'h0, 16'h0, 16'h0);
    chk_val("clamp", 24'h119999, volts);
    chk_bit("ovl", 1'b1, fl.overload_flag);
    drive(-24'sh10000, 24'h0, QTY_X);
    chk_val("nclamp", 24'hEE6667, volts);
    drive(24'h100, 24'h0, QTY_X);
    chk_val("inside", 24'h6400, volts);
    chk_bit("ovl", 1'b0, fl.overload_flag);
    key(EXP, 16'h0, 16'h0, 16'h0);
  endtask
  task automatic t_offset;
    drive(24'h8000, 24'h0, QTY_X);
    key(WR, 16'sh0190, 16'h0, 16'h0);
    chk_val("pct", 24'h190, pct);
    key(TOG, 16'h0, 16'h0, 16'h0);
    chk_val("xoff", 24'h4000, volts);
    chk_bit("xyf", 1'b1, fl.xy_offset_flag);
    drive(24'h8000, 24'h0, QTY_Y);
    chk_bit("xyf y", 1'b1, fl.xy_offset_flag);
    key(PH, 16'h0, 16'h0, 16'h4000);
    chk_val("yrot", 24'h4000, disp);
    chk_val("xrot", 24'h8000, volts);
    chk_val("ypct", 24'hFFFE70, pct);
    key(TOG, 16'h0, 16'h0, 16'h0);
    chk_bit("xyf y", 1'b0, fl.xy_offset_flag);
    drive(24'h8000, 24'h0, QTY_X);
    chk_bit("xyf x", 1'b0, fl.xy_offset_flag);
    chk_val("xplain", 24'h8000, volts);
  endtask
  task automatic t_rsel;
    key(EXP, 16'h0, 16'h0, 16'h0);
    drive(24'h8000, 24'h0, QTY_R);
    chk_val("xout", 24'h50000, volts);
    chk_val("rdisp", 24'h8000, disp);
    chk_bit("expf r", 1'b0, fl.expand_flag);
    key(EXP, 16'h0, 16'h0, 16'h0);
    key(EXP, 16'h0, 16'h0, 16'h0);
    chk_val("rx100", 24'h119999, disp);
    chk_val("xkeep", 24'h50000, volts);
    key(OUTK, 16'h0, 16'h0, 16'h0);
    chk_bit("src", 1'b1, fl.output_is_display);
    chk_val("rout", 24'h119999, volts);
    key(EXP, 16'h0, 16'h0, 16'h0);
    chk_val("rout", 24'h8000, volts);
    drive(24'h8000, 24'h2000, QTY_Y);
    chk_val("yout", 24'h2000, volts);
    key(EXP, 16'h0, 16'h0, 16'h0);
    chk_val("yexp", 24'h14000, volts);
    key(OUTK, 16'h0, 16'h0, 16'h0);
    chk_bit("src", 1'b0, fl.output_is_display);
    drive(24'h8000, 24'h0, QTY_X);
    key(AUTO, 16'h0, 16'h0, 16'h0);
    chk_val("auto", 24'h0, volts);
    chk_val("apct", 24'h320, pct);
    drive(24'h8000, 24'h0, QTY_R);
    chk_val("r xy", 24'h0, disp);
    key(TOG, 16'h0, 16'h0, 16'h0);
    chk_bit("roff", 1'b1, fl.magnitude_offset_flag);
    chk_bit("xyf r", 1'b1, fl.xy_offset_flag);
    key(TOG, 16'h0, 16'h0, 16'h0);
    chk_bit("roff", 1'b0, fl.magnitude_offset_flag);
    key(WR, 16'sh0100, 16'h0, 16'h0);
    chk_val("rpct", 24'h100, pct);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_i);
    chk_val("rst out", 24'h0, aout);
    chk_bit("rst src", 1'b0, fl.output_is_display);
    rst_i = 1'b0;
    t_expand;
    t_clamp;
    t_offset;
    t_rsel;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    error_cnt++;
    finish_test;
  end
endmodule
